// >>> core/qec_top.sv
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module qec_top #(
  parameter int MS_CYC = qec_pkg::MS_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Differential receiver inputs
  input wire logic [3:0] diff_phase_a,
  input wire logic [3:0] diff_phase_b,
  input wire logic [3:0] diff_index_clear_input,
  input wire logic [3:0] diff_gp_in,
  // Logic-level inputs
  input wire logic [3:0] ttl_phase_a,
  input wire logic [3:0] ttl_phase_b,
  input wire logic [3:0] ttl_index_clear_input,
  input wire logic [3:0] ttl_gp_in,
  // Outputs
  output logic [3:0] match_out,
  output logic irq
);
  localparam int NCH = qec_pkg::NCH;
  localparam int CW = qec_pkg::CW;
  localparam int MSW = $clog2(MS_CYC + 1);
  localparam logic [1:0] FPRE_END = 2'(qec_pkg::FLT_STEP_CYC - 1);

  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_d;
  logic wr_go;
  logic [CW-1:0] cnt_q [NCH];
  logic [CW-1:0] cmp_q [NCH];
  logic [31:0] cfg_q [NCH];
  logic [qec_pkg::PW_W-1:0] pw_q;
  logic [qec_pkg::TPER_W-1:0] tper_q;
  logic ten_q;
  logic [qec_pkg::NEV-1:0] sts_q;
  logic [qec_pkg::NEV-1:0] msk_q;
  logic [qec_pkg::NEV-1:0] ev;
  logic irq_q;
  logic [NCH-1:0] eq_q;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] mo_q;
  logic [qec_pkg::PCNT_W-1:0] pcnt_q [NCH];
  logic [qec_pkg::PCNT_W-1:0] pw_len;
  logic [1:0] ab_q [NCH];
  logic [3:0] raw [NCH];
  logic [7:0] pin_meta_q [NCH];
  logic [7:0] pin_sync_q [NCH];
  logic [1:0] stp [NCH];
  logic [NCH-1:0] same;
  logic [3:0] cln [NCH];
  logic [1:0] fpre_q;
  logic ftick_q;
  logic [MSW-1:0] ms_q;
  logic [qec_pkg::TPER_W-1:0] msn_q;
  logic tmr_ev;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : be_merge

  // True when the address selects the given register of the given channel.
  function automatic logic ch_hit(logic [7:0] a, int ch, logic [3:0] off);
    return (a < qec_pkg::CH_AREA_END) && (int'(a[5:4]) == ch) && (a[3:0] == off);
  endfunction : ch_hit

  // Returns {count enable, up}; quadrature decodes every edge of both phases.
  function automatic logic [1:0] step(logic updn, logic [1:0] o, logic [1:0] n);
    logic ra;
    logic rb;
    ra = n[0] & ~o[0];
    rb = n[1] & ~o[1];
    if (updn) return {ra ^ rb, ra};
    // A simultaneous change of both phases is a lost step and is not counted.
    return {(o[0] ^ n[0]) ^ (o[1] ^ n[1]), n[0] ^ o[1]};
  endfunction : step

  //////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the access completes.
  // Waitrequest comes from a flop, so it costs a cycle per access but never glitches.

  assign wr_go = avs_write && !wait_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) wait_q <= 1'b1;
    else wait_q <= !((avs_read || avs_write) && wait_q);
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    for (int c = 0; c < NCH; c++) begin
      if (ch_hit(avs_address, c, qec_pkg::OFF_CNT)) rd_d = {8'h00, cnt_q[c]};
      if (ch_hit(avs_address, c, qec_pkg::OFF_CMP)) rd_d = {8'h00, cmp_q[c]};
      if (ch_hit(avs_address, c, qec_pkg::OFF_CFG)) rd_d = cfg_q[c];
    end
    unique case (avs_address)
      qec_pkg::OFF_PW: rd_d = {18'h0_0000, pw_q};
      qec_pkg::OFF_TPER: rd_d = {14'h0000, tper_q};
      qec_pkg::OFF_TCTL: rd_d = {31'h0000_0000, ten_q};
      qec_pkg::OFF_STS: rd_d = {27'h000_0000, sts_q};
      qec_pkg::OFF_MSK: rd_d = {27'h000_0000, msk_q};
      // General inputs read back after the same filter as the counting inputs.
      qec_pkg::OFF_GPI: rd_d = {28'h000_0000, cln[3][3], cln[2][3], cln[1][3], cln[0][3]};
      default: ;
    endcase
  end

  // The whole count is caught in one edge, so no partial carry is ever seen.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rdata_q <= 32'h0000_0000;
    else if (avs_read && wait_q) rdata_q <= rd_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        cmp_q[c] <= qec_pkg::CMP_RST;
        cfg_q[c] <= qec_pkg::CFG_RST;
      end
      pw_q <= qec_pkg::PW_RST;
      tper_q <= qec_pkg::TPER_RST;
      ten_q <= 1'b0;
      msk_q <= qec_pkg::MSK_RST;
    end else if (wr_go) begin
      for (int c = 0; c < NCH; c++) begin
        if (ch_hit(avs_address, c, qec_pkg::OFF_CMP)) begin
          cmp_q[c] <= CW'(be_merge({8'h00, cmp_q[c]}, avs_writedata, avs_byteenable));
        end
        if (ch_hit(avs_address, c, qec_pkg::OFF_CFG)) begin
          cfg_q[c] <= be_merge(cfg_q[c], avs_writedata, avs_byteenable) & qec_pkg::CFG_WMASK;
        end
      end
      if (avs_address == qec_pkg::OFF_PW) begin
        pw_q <= qec_pkg::PW_W'(be_merge({18'h0_0000, pw_q}, avs_writedata, avs_byteenable));
      end
      if (avs_address == qec_pkg::OFF_TPER) begin
        tper_q <= qec_pkg::TPER_W'(be_merge({14'h0000, tper_q}, avs_writedata,
                                            avs_byteenable));
      end
      if (avs_address == qec_pkg::OFF_TCTL && avs_byteenable[0]) ten_q <= avs_writedata[0];
      if (avs_address == qec_pkg::OFF_MSK && avs_byteenable[0]) begin
        msk_q <= avs_writedata[qec_pkg::NEV-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Both input paths are sampled before the selector. It doubles the flops, but a
  // source switch can then never hand a half-settled pin level to the filter.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        pin_meta_q[c] <= 8'h00;
        pin_sync_q[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        pin_meta_q[c] <= {ttl_gp_in[c], ttl_index_clear_input[c], ttl_phase_b[c], ttl_phase_a[c],
                          diff_gp_in[c], diff_index_clear_input[c], diff_phase_b[c],
                          diff_phase_a[c]};
        pin_sync_q[c] <= pin_meta_q[c];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Input selection and filtering

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fpre_q <= 2'h0;
      ftick_q <= 1'b0;
    end else begin
      ftick_q <= (fpre_q == FPRE_END);
      if (fpre_q == FPRE_END) fpre_q <= 2'h0;
      else fpre_q <= fpre_q + 2'h1;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    // The selector only ever sees synchronised levels.
    assign raw[g] = cfg_q[g][qec_pkg::CFG_SRC] ? pin_sync_q[g][7:4] :
                    pin_sync_q[g][3:0];

    qec_filt #(
      .W(4),
      .LW(qec_pkg::FLT_W)
    ) u_filt (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(ftick_q),
      .limit(cfg_q[g][qec_pkg::CFG_FLT_LSB +: qec_pkg::FLT_W]),
      .raw(raw[g]),
      .clean(cln[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Counters

  // Stepping is decoded in its own process so the counter update stays non-blocking.
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      stp[c] = step(cfg_q[c][qec_pkg::CFG_MODE], ab_q[c], cln[c][1:0]);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        cnt_q[c] <= '0;
        ab_q[c] <= 2'h0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        ab_q[c] <= cln[c][1:0];
        // Index clear outranks a preset write and counting while its level stays high.
        if (cfg_q[c][qec_pkg::CFG_CLR] && cln[c][2]) begin
          cnt_q[c] <= '0;
        end else if (wr_go && ch_hit(avs_address, c, qec_pkg::OFF_CNT)) begin
          cnt_q[c] <= CW'(be_merge({8'h00, cnt_q[c]}, avs_writedata, avs_byteenable));
        end else if (stp[c][1]) begin
          // The count wraps through zero in both directions.
          cnt_q[c] <= stp[c][0] ? cnt_q[c] + 1'b1 : cnt_q[c] - 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Compare match and one-shot output

  // Only the arrival at the compare value fires, not the dwell on it.
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      same[c] = (cnt_q[c] == cmp_q[c]);
      hit[c] = same[c] && !eq_q[c];
    end
  end

  assign pw_len = qec_pkg::PCNT_W'(int'(pw_q) * qec_pkg::PW_STEP_CYC);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Count and compare both leave reset at zero, so the pair starts out equal and
      // reset itself is never reported as an arrival at the compare value.
      eq_q <= '1;
      mo_q <= '0;
      for (int c = 0; c < NCH; c++) pcnt_q[c] <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        eq_q[c] <= same[c];
        // A new match restarts the pulse; a zero width gives no pulse at all.
        if (hit[c] && pw_q != '0) begin
          pcnt_q[c] <= pw_len;
          mo_q[c] <= 1'b1;
        end else if (pcnt_q[c] != '0) begin
          pcnt_q[c] <= pcnt_q[c] - 1'b1;
          if (pcnt_q[c] == qec_pkg::PCNT_W'(1)) mo_q[c] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Periodic timer

  // The millisecond prescaler restarts on every enable, so the first event
  // comes a full period after the enable is written.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_q <= '0;
      msn_q <= '0;
      tmr_ev <= 1'b0;
    end else begin
      tmr_ev <= 1'b0;
      if (!ten_q) begin
        ms_q <= '0;
        msn_q <= '0;
      end else if (ms_q == MSW'(MS_CYC - 1)) begin
        ms_q <= '0;
        // A period of zero is treated as the shortest period, one millisecond.
        if (msn_q + 1'b1 >= tper_q) begin
          msn_q <= '0;
          tmr_ev <= 1'b1;
        end else begin
          msn_q <= msn_q + 1'b1;
        end
      end else begin
        ms_q <= ms_q + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status

  assign ev = {tmr_ev, hit};

  // A new event in the cycle of its write-one-to-clear keeps the bit set.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_q <= '0;
    end else if (wr_go && avs_address == qec_pkg::OFF_STS && avs_byteenable[0]) begin
      sts_q <= (sts_q & ~avs_writedata[qec_pkg::NEV-1:0]) | ev;
    end else begin
      sts_q <= sts_q | ev;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) irq_q <= 1'b0;
    else irq_q <= |(sts_q & msk_q);
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign match_out = mo_q;
  assign irq = irq_q;
endmodule : qec_top

// >>> core/qec_pkg.sv
package qec_pkg;
  localparam int NCH = 4;
  localparam int CW = 24;
  localparam int FLT_W = 14;
  localparam int PW_W = 14;
  localparam int TPER_W = 18;
  localparam int PCNT_W = 22;
  localparam int NEV = 5;

  // Register byte offsets; channel registers repeat every stride below the area end.
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] CH_AREA_END = 8'h40;
  localparam logic [3:0] OFF_CNT = 4'h0;
  localparam logic [3:0] OFF_CMP = 4'h4;
  localparam logic [3:0] OFF_CFG = 4'h8;
  localparam logic [7:0] OFF_PW = 8'h40;
  localparam logic [7:0] OFF_TPER = 8'h44;
  localparam logic [7:0] OFF_TCTL = 8'h48;
  localparam logic [7:0] OFF_STS = 8'h4c;
  localparam logic [7:0] OFF_MSK = 8'h50;
  localparam logic [7:0] OFF_GPI = 8'h54;

  // Channel configuration fields.
  localparam int CFG_MODE = 0;
  localparam int CFG_SRC = 1;
  localparam int CFG_CLR = 2;
  localparam int CFG_FLT_LSB = 16;
  localparam logic [31:0] CFG_WMASK = 32'h3fff_0007;
  localparam int STS_TMR = 4;

  // Values after reset.
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [CW-1:0] CMP_RST = 24'h00_0000;
  localparam logic [PW_W-1:0] PW_RST = 14'h0000;
  localparam logic [TPER_W-1:0] TPER_RST = 18'h0_0001;
  localparam logic [NEV-1:0] MSK_RST = 5'h00;

  // Timing at the 40 ns reference clock.
  localparam int CLK_NS = 40;
  localparam int FLT_STEP_NS = 100;
  localparam int FLT_STEP_CYC = (FLT_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PW_STEP_NS = 10000;
  localparam int PW_STEP_CYC = PW_STEP_NS / CLK_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
endpackage : qec_pkg

// >>> core/qec_filt.sv
`timescale 1ns/1ps
module qec_filt #(
  parameter int W = 4,
  parameter int LW = 14
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Filter control
  input wire logic tick,
  input wire logic [LW-1:0] limit,
  // Levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  logic [W-1:0] cln_q;
  logic [LW-1:0] cnt_q [W];

  // The caller hands in synchronised levels, so no pin reaches this logic unsampled.
  // A new level is taken only after it has held for limit+1 filter ticks.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cln_q <= '0;
      for (int i = 0; i < W; i++) cnt_q[i] <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (raw[i] == cln_q[i]) begin
          cnt_q[i] <= '0;
        end else if (tick) begin
          if (cnt_q[i] >= limit) begin
            cln_q[i] <= raw[i];
            cnt_q[i] <= '0;
          end else begin
            cnt_q[i] <= cnt_q[i] + 1'b1;
          end
        end
      end
    end
  end

  assign clean = cln_q;
endmodule : qec_filt

// >>> dv/qec_enc_model.sv
`timescale 1ns/1ps
module qec_enc_model (
  // Clock
  input wire logic ref_clk,
  // Differential side
  output logic [3:0] d_a,
  output logic [3:0] d_b,
  output logic [3:0] d_z,
  output logic [3:0] d_g,
  // Logic-level side
  output logic [3:0] t_a,
  output logic [3:0] t_b,
  output logic [3:0] t_z,
  output logic [3:0] t_g
);
  logic [3:0] a, b, z, g, src;

  initial begin
    {a, b, z, g, src} = '0;
  end

  // The unused path shows swapped phases, so a mux on the wrong path counts backwards.
  assign d_a = (a & ~src) | (b & src);
  assign d_b = (b & ~src) | (a & src);
  assign t_a = (a & src) | (b & ~src);
  assign t_b = (b & src) | (a & ~src);
  assign d_z = z ^ src;
  assign t_z = z ^ ~src;
  assign d_g = g ^ src;
  assign t_g = g ^ ~src;

  //////////////////////////////////////////////////////////////////////////////
  task automatic quad(input int ch, input int n);
    repeat (n < 0 ? -n : n) begin
      if ((a[ch] == b[ch]) == (n > 0)) a[ch] <= ~a[ch];
      else b[ch] <= ~b[ch];
      repeat (10) @(posedge ref_clk);
    end
  endtask : quad

  task automatic ud(input int ch, input logic up, input int n);
    repeat (n) begin
      if (up) a[ch] <= 1'b1;
      else b[ch] <= 1'b1;
      repeat (10) @(posedge ref_clk);
      a[ch] <= 1'b0;
      b[ch] <= 1'b0;
      repeat (10) @(posedge ref_clk);
    end
  endtask : ud
endmodule : qec_enc_model

// >>> dv/qec_top_asserts.sv
`timescale 1ns/1ps
module qec_top_asserts #(
  parameter int MS_CYC = qec_pkg::MS_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Outputs
  input wire logic [3:0] match_out,
  input wire logic irq
);
  logic [13:0] pw_q;
  logic [4:0] msk_q;
  logic [21:0] hi_q;
  logic wr_ok;

  assign wr_ok = avs_write && !avs_waitrequest;

  // Shadow copies of width and mask, taken at the same edge the slave takes them.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pw_q <= qec_pkg::PW_RST;
      msk_q <= qec_pkg::MSK_RST;
    end else if (wr_ok && avs_address == qec_pkg::OFF_PW) begin
      pw_q <= avs_writedata[13:0];
    end else if (wr_ok && avs_address == qec_pkg::OFF_MSK) begin
      msk_q <= avs_writedata[4:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) hi_q <= 22'h0;
    else hi_q <= match_out[0] ? hi_q + 22'h1 : 22'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence req_seen;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence hole_read;
    avs_read && avs_address >= 8'h58 ##1 !avs_waitrequest;
  endsequence

  wait_reset_a: assert property ($rose(rst_n) |-> avs_waitrequest && !irq && match_out == 4'h0)
    else $error("bus or outputs active right after reset");
  one_wait_a: assert property (req_seen |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  hole_zero_a: assert property (hole_read |-> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  pulse_width_a: assert property ($fell(match_out[0]) |-> hi_q == pw_q * 250)
    else $error("match pulse width wrong");
  mask_quiet_a: assert property ((msk_q == 5'h00) [*3] |-> !irq)
    else $error("interrupt raised while fully masked");
  match_irq_a: assert property ($rose(match_out[0]) && msk_q[0] |=> irq)
    else $error("match did not raise interrupt");
endmodule : qec_top_asserts

bind qec_top qec_top_asserts #(.MS_CYC(MS_CYC)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .match_out(match_out), .irq(irq));

// >>> dv/quad_encoder_counter_with_match_test.sv
`timescale 1ns/1ps
module quad_encoder_counter_with_match_test;
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [3:0] da, db, dz, dg, ta, tb, tz, tg, match_out;
  int bad_count;
  int checked;

  qec_top #(.MS_CYC(10)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .diff_phase_a(da), .diff_phase_b(db), .diff_index_clear_input(dz), .diff_gp_in(dg),
    .ttl_phase_a(ta), .ttl_phase_b(tb), .ttl_index_clear_input(tz), .ttl_gp_in(tg),
    .match_out(match_out), .irq(irq));
  qec_enc_model enc (.ref_clk(ref_clk), .d_a(da), .d_b(db), .d_z(dz), .d_g(dg),
    .t_a(ta), .t_b(tb), .t_z(tz), .t_g(tg));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  // One Avalon cycle; the extra edge at the end keeps two requests from sharing a time step.
  // Only the watchdog ends a wait that never finishes.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 4'hf);
    chk(rdata, e);
  endtask : rd

  task automatic irq_is(input logic v);
    idle(2);
    @(negedge ref_clk);
    chk({31'h0, irq}, {31'h0, v});
    @(posedge ref_clk);
  endtask : irq_is

  function automatic logic [7:0] ca(input int c, input logic [3:0] o);
    return 8'(c) * qec_pkg::CH_STRIDE + {4'h0, o};
  endfunction : ca

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
    rst_n = 1'b0;
    bad_count = 0;
    checked = 0;
    idle(4);
    rst_n <= 1'b1;
    idle(1);
    rd(ca(0, qec_pkg::OFF_CFG), qec_pkg::CFG_RST);
    rd(qec_pkg::OFF_TPER, 32'h1);
    rd(qec_pkg::OFF_STS, 32'h0);
    rd(8'hfc, 32'h0);
    wr(ca(0, qec_pkg::OFF_CMP), 32'hffff_ffff);
    rd(ca(0, qec_pkg::OFF_CMP), 32'h00ff_ffff);
    acc(1'b1, ca(0, qec_pkg::OFF_CMP), 32'haaaa_aa12, 4'h1);
    rd(ca(0, qec_pkg::OFF_CMP), 32'h00ff_ff12);
    wr(ca(1, qec_pkg::OFF_CFG), 32'hffff_ffff);
    rd(ca(1, qec_pkg::OFF_CFG), qec_pkg::CFG_WMASK);
    wr(ca(1, qec_pkg::OFF_CFG), 32'h0014_0000);
    wr(qec_pkg::OFF_MSK, 32'h1f);
    wr(qec_pkg::OFF_PW, 32'h1);
    wr(ca(0, qec_pkg::OFF_CMP), 32'h5);
    enc.quad(0, 5);
    // Every phase level lasts 20 cycles, well short of the 63-cycle filter on channel 1.
    enc.quad(1, 4);
    idle(20);
    rd(ca(0, qec_pkg::OFF_CNT), 32'h5);
    rd(ca(1, qec_pkg::OFF_CNT), 32'h0);
    rd(qec_pkg::OFF_STS, 32'h1);
    @(negedge ref_clk);
    chk({28'h0, match_out}, 32'h1);
    @(posedge ref_clk);
    irq_is(1'b1);
    wr(qec_pkg::OFF_STS, 32'h1);
    irq_is(1'b0);
    enc.quad(0, -2);
    idle(20);
    rd(ca(0, qec_pkg::OFF_CNT), 32'h3);
    wr(ca(2, qec_pkg::OFF_CFG), 32'h1);
    enc.ud(2, 1'b1, 3);
    enc.ud(2, 1'b0, 1);
    idle(20);
    rd(ca(2, qec_pkg::OFF_CNT), 32'h2);
    wr(ca(3, qec_pkg::OFF_CFG), 32'h2);
    enc.src <= 4'h8;
    enc.quad(3, 3);
    idle(20);
    rd(ca(3, qec_pkg::OFF_CNT), 32'h3);
    wr(ca(3, qec_pkg::OFF_CNT), 32'h00ff_ffff);
    enc.quad(3, 1);
    idle(20);
    rd(ca(3, qec_pkg::OFF_CNT), 32'h0);
    rd(qec_pkg::OFF_STS, 32'h8);
    @(negedge ref_clk);
    chk({28'h0, match_out}, 32'h8);
    @(posedge ref_clk);
    wr(ca(0, qec_pkg::OFF_CFG), 32'h4);
    enc.z <= 4'h1;
    idle(20);
    rd(ca(0, qec_pkg::OFF_CNT), 32'h0);
    enc.z <= 4'h0;
    enc.g <= 4'h5;
    idle(100);
    rd(qec_pkg::OFF_GPI, 32'h5);
    wr(qec_pkg::OFF_MSK, 32'h0);
    wr(qec_pkg::OFF_STS, 32'h1f);
    wr(qec_pkg::OFF_TPER, 32'h2);
    wr(qec_pkg::OFF_TCTL, 32'h1);
    idle(30);
    rd(qec_pkg::OFF_STS, 32'h10);
    irq_is(1'b0);
    wr(qec_pkg::OFF_MSK, 32'h10);
    irq_is(1'b1);
    wr(qec_pkg::OFF_TCTL, 32'h0);
    wr(qec_pkg::OFF_STS, 32'h1f);
    rd(qec_pkg::OFF_STS, 32'h0);
    irq_is(1'b0);
    summarize();
  end

  initial begin
    idle(20000);
    bad_count++;
    summarize();
  end
endmodule : quad_encoder_counter_with_match_test
